/* core/rcf_reset_cause.sv */
// Reset-cause recording: cause flags, time-out / power-down state bits and
// the program counter restart point.
// Assumes: reset is the power-on reset of the core clock domain; other
// reset and wake requests arrive as levels (pins) or one-cycle pulses.
//
// Operation
// (RULE1) Every reset event updates its cause bits; the code records only the highest-priority one per cycle
// (RULE2) Power-on: vector 0000h, state bits 1 1000
// (RULE3) Power-on: cause register loads 00-1 110x
// (RULE4) Software rewrites power-on flag to one afterwards
// (RULE5) Brown-out: 0000h, state 1 1uuu, cause 00-1 11u0
// (RULE6) Watchdog reset clears watchdog flag and time-out
// (RULE7) Watchdog in sleep: state 0 0uuu, PC+1
// (RULE8) Interrupt wake: state 1 0uuu, next instruction
// (RULE9) Wake with interrupts enabled then vectors 0004h
// (RULE10) Pin reset awake clears pin flag only
// (RULE11) Pin reset asleep: also state 1 0uuu
// (RULE12) Reset instruction clears instruction flag, restarts 0000h
// (RULE13) Enabled stack overflow sets overflow flag, restarts
// (RULE14) Enabled stack underflow sets underflow flag, restarts
// (RULE15) Firmware reads and writes every implemented flag
// (RULE16) Fixed cause bit positions, overflow at bit seven
// (RULE17) Bit five and unimplemented bits read zero
// (RULE18) Low-power brown-out ORed with main brown-out
// (RULE19) Hardware update beats same-cycle firmware write
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "rcf_consts.svh"
module rcf_reset_cause
    import rcf_pkg::*;
(
    input  wire logic        sys_clk,          // Core clock, 40 MHz
    input  wire logic        reset,            // Power-on reset, async high
    input  wire logic        brownout_req,     // Main brown-out request pin
    input  wire logic        lp_brownout_req,  // Low-power detector request
    input  wire logic        ext_reset_pin,    // Pin level, low = reset
    input  wire logic        wdt_expire,       // Watchdog expiry pulse
    input  wire logic        soft_reset_exec,  // Reset instruction pulse
    input  wire logic        stack_ovf_evt,    // Stack overflow pulse
    input  wire logic        stack_unf_evt,    // Stack underflow pulse
    input  wire logic        irq_wake,         // Interrupt wake pulse
    input  wire logic        sleep_enter,      // Sleep instruction pulse
    input  wire logic        next_instr_done,  // Post-sleep instr retired
    input  wire logic [12:0] cur_pc,           // PC of the sleep instruction
    input  wire logic [1:0]  reg_addr,         // Register address
    input  wire logic [7:0]  reg_wdata,        // Register write data
    input  wire logic        reg_wr,           // Write strobe
    input  wire logic        reg_rd,           // Read strobe
    output logic      [7:0]  reg_rdata,        // Read data, cycle after rd
    output logic             core_hold,        // Core held in reset
    output logic             pc_load,          // PC load pulse
    output logic      [12:0] pc_vector,        // PC value to load
    output logic             irq_push          // Push return address pulse
);
    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    logic [1:0] pin_sync;
    logic       brn_lvl;
    logic       pin_low;
    logic       brn_q_ff;
    logic       pin_q_ff;
    logic       brn_evt;
    logic       pin_evt;

    rcf_sync3 #(.W(2)) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({brownout_req | lp_brownout_req, ~ext_reset_pin}), // RULE18
        .sync_out (pin_sync)
    );

    assign brn_lvl = pin_sync[1];
    assign pin_low = pin_sync[0];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            brn_q_ff <= 1'b0;
            pin_q_ff <= 1'b0;
        end else begin
            brn_q_ff <= brn_lvl;
            pin_q_ff <= pin_low;
        end
    end

    // Flags update on the asserting edge; the core is held while either request is asserted
    assign brn_evt = brn_lvl & ~brn_q_ff;
    assign pin_evt = pin_low & ~pin_q_ff;

    // ------------------------------------------------------------------
    // Sleep tracking and event priority
    // ------------------------------------------------------------------
    logic       asleep_ff;
    logic       stack_en_ff;
    logic       irq_en_ff;
    logic       sw_wr;
    logic       stack_ovf_rst;
    logic       stack_unf_rst;
    rcf_event_t ev;

    assign sw_wr         = reg_wr & (reg_addr == `RCF_OFS_CAUSE);
    assign stack_ovf_rst = stack_ovf_evt & stack_en_ff;
    assign stack_unf_rst = stack_unf_evt & stack_en_ff;

    // Brown-out outranks everything; only one cause is recorded per cycle
    always_comb begin
        ev = RCF_EV_NONE;
        if (brn_evt) begin
            ev = RCF_EV_BROWNOUT;
        end else if (pin_evt) begin
            ev = RCF_EV_PIN;
        end else if (wdt_expire) begin
            ev = RCF_EV_WDT;
        end else if (soft_reset_exec) begin
            ev = RCF_EV_SOFT;
        end else if (stack_ovf_rst) begin
            ev = RCF_EV_OVF;
        end else if (stack_unf_rst) begin
            ev = RCF_EV_UNF;
        end
    end

    // ------------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------------
    logic [7:0] cause_ff;
    logic [7:0] nxt_cause;

    always_comb begin
        nxt_cause = cause_ff;
        if (sw_wr) begin
            nxt_cause = reg_wdata & `RCF_IMPL_MASK; // RULE15 RULE17
        end
        // Hardware after software so it wins on the same bit
        unique case (ev) // RULE19
            RCF_EV_BROWNOUT: begin
                nxt_cause[`RCF_BIT_OVF]    = 1'b0; // RULE5
                nxt_cause[`RCF_BIT_UNF]    = 1'b0;
                nxt_cause[`RCF_BIT_WDT]    = 1'b1;
                nxt_cause[`RCF_BIT_PIN]    = 1'b1;
                nxt_cause[`RCF_BIT_SRI]    = 1'b1;
                nxt_cause[`RCF_BIT_BROWN]  = 1'b0;
            end
            RCF_EV_WDT: begin
                if (!asleep_ff) begin
                    nxt_cause[`RCF_BIT_WDT] = 1'b0; // RULE6
                end
            end
            RCF_EV_PIN:    nxt_cause[`RCF_BIT_PIN]    = 1'b0; // RULE10 RULE11
            RCF_EV_SOFT:   nxt_cause[`RCF_BIT_SRI]    = 1'b0; // RULE12
            RCF_EV_OVF:    nxt_cause[`RCF_BIT_OVF]    = 1'b1; // RULE13
            RCF_EV_UNF:    nxt_cause[`RCF_BIT_UNF]    = 1'b1; // RULE14
            RCF_EV_NONE:   ;
        endcase
    end

    // Power-on flag is only cleared here; software restores it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cause_ff <= `RCF_CAUSE_POR; // RULE3 RULE4
        end else begin
            cause_ff <= nxt_cause; // RULE1 RULE16
        end
    end

    // ------------------------------------------------------------------
    // Time-out / power-down state bits
    // ------------------------------------------------------------------
    logic [4:0] state_ff;
    logic [4:0] nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (sleep_enter) begin
            nxt_state[`RCF_BIT_PDOWN] = 1'b0;
        end
        unique case (ev)
            RCF_EV_BROWNOUT: begin
                nxt_state[`RCF_BIT_TOUT]  = 1'b1; // RULE5
                nxt_state[`RCF_BIT_PDOWN] = 1'b1;
            end
            RCF_EV_WDT: begin
                nxt_state[`RCF_BIT_TOUT] = 1'b0; // RULE6 RULE7
                if (asleep_ff) begin
                    nxt_state[`RCF_BIT_PDOWN] = 1'b0;
                end
            end
            RCF_EV_PIN: begin
                if (asleep_ff) begin
                    nxt_state[`RCF_BIT_TOUT]  = 1'b1; // RULE11
                    nxt_state[`RCF_BIT_PDOWN] = 1'b0;
                end
            end
            default: ;
        endcase
        if (ev == RCF_EV_NONE && irq_wake && asleep_ff) begin
            nxt_state[`RCF_BIT_TOUT]  = 1'b1; // RULE8
            nxt_state[`RCF_BIT_PDOWN] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_ff <= `RCF_STATE_POR; // RULE2
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Sleep, config and wake sequencing
    // ------------------------------------------------------------------
    logic wake_now;
    logic irq_pend_ff;

    assign wake_now = asleep_ff & ((ev == RCF_EV_WDT) |
                      (ev == RCF_EV_NONE & irq_wake));

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            asleep_ff <= 1'b0;
        end else if (ev != RCF_EV_NONE || wake_now) begin
            asleep_ff <= 1'b0;
        end else if (sleep_enter) begin
            asleep_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stack_en_ff <= 1'b0;
            irq_en_ff   <= 1'b0;
        end else if (reg_wr && reg_addr == `RCF_OFS_CONFIG) begin
            stack_en_ff <= reg_wdata[0];
            irq_en_ff   <= reg_wdata[1];
        end
    end

    // Vector only after the instruction past the sleep retires
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_pend_ff <= 1'b0;
        end else if (ev != RCF_EV_NONE) begin
            irq_pend_ff <= 1'b0;
        end else if (wake_now && irq_wake && irq_en_ff) begin
            irq_pend_ff <= 1'b1; // RULE9
        end else if (next_instr_done) begin
            irq_pend_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Program counter restart
    // ------------------------------------------------------------------
    logic resets_pc;

    // Watchdog expiry in sleep is a wake, not a restart
    assign resets_pc = (ev != RCF_EV_NONE) &
                       ~(ev == RCF_EV_WDT & asleep_ff);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pc_load   <= 1'b1; // RULE2
            pc_vector <= `RCF_VEC_RESET;
            irq_push  <= 1'b0;
        end else if (resets_pc) begin
            pc_load   <= 1'b1;
            pc_vector <= `RCF_VEC_RESET;
            irq_push  <= 1'b0;
        end else if (wake_now) begin
            pc_load   <= 1'b1; // RULE7 RULE8
            pc_vector <= cur_pc + 13'h0001;
            irq_push  <= 1'b0;
        end else if (irq_pend_ff && next_instr_done) begin
            pc_load   <= 1'b1; // RULE9
            pc_vector <= `RCF_VEC_IRQ;
            irq_push  <= 1'b1;
        end else begin
            pc_load   <= 1'b0;
            pc_vector <= pc_vector;
            irq_push  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            core_hold <= 1'b1;
        end else begin
            core_hold <= brn_lvl | pin_low;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RCF_OFS_CAUSE:  reg_rdata <= cause_ff & `RCF_IMPL_MASK;
                `RCF_OFS_STATE:  reg_rdata <= {3'h0, state_ff};
                `RCF_OFS_CONFIG: reg_rdata <= {6'h00, irq_en_ff,
                                               stack_en_ff};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

/* core/rcf_consts.svh */
// Constants of the reset-cause flag block: field positions, reset values,
// restart vectors and register offsets.
// Assumes inclusion by bare name from the block's design files.
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

// Register offsets on the plain register port
`define RCF_OFS_CAUSE      2'h0
`define RCF_OFS_STATE      2'h1
`define RCF_OFS_CONFIG     2'h2

// Cause register bit positions
`define RCF_BIT_OVF        7
`define RCF_BIT_UNF        6
`define RCF_BIT_UNUSED     5
`define RCF_BIT_WDT        4
`define RCF_BIT_PIN        3
`define RCF_BIT_SRI        2
`define RCF_BIT_POR        1
`define RCF_BIT_BROWN      0

// State register bit positions (upper state bits)
`define RCF_BIT_TOUT       4
`define RCF_BIT_PDOWN      3

// Power-on values and implemented-bit mask
`define RCF_CAUSE_POR      8'h1C
`define RCF_STATE_POR      5'h18
`define RCF_BROWN_POR_VAL  1'h0
`define RCF_IMPL_MASK      8'hDF

// Restart points
`define RCF_VEC_RESET      13'h0000
`define RCF_VEC_IRQ        13'h0004

`endif

/* core/rcf_pkg.sv */
// Types shared by the reset-cause flag block.
// Assumes rcf_consts.svh is on the include path.
package rcf_pkg;

    typedef enum logic [2:0] {
        RCF_EV_NONE,
        RCF_EV_BROWNOUT,
        RCF_EV_WDT,
        RCF_EV_PIN,
        RCF_EV_SOFT,
        RCF_EV_OVF,
        RCF_EV_UNF
    } rcf_event_t;

    typedef struct packed {
        logic        restart;
        logic [12:0] vector;
    } rcf_pc_cmd_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  addr;
        logic [7:0]  wdata;
    } rcf_bus_req_t;

endpackage

/* core/rcf_sync3.sv */
// Three-stage synchroniser for asynchronous request levels.
// Assumes one clock domain; the change counts when stages two and three
// agree, so the first stage feeds only the second.
`timescale 1ns/1ps
module rcf_sync3 #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,   // Core clock
    input  wire logic         reset,     // Async reset, active high
    input  wire logic [W-1:0] async_in,  // Level from outside the domain
    output logic      [W-1:0] sync_out   // Filtered synchronous level
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_out;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Output moves only where the two later stages agree
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            assign nxt_out[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g]
                                                      : sync_out[g];
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync_out <= '0;
        end else begin
            sync_out <= nxt_out;
        end
    end
endmodule

/* verif/rcf_reset_cause_assertions.sv */
// Concurrent checks on the ports of the reset-cause block.
// Assumes a bind from the bench top; one clock, reset async high.
`timescale 1ns/1ps
`include "rcf_consts.svh"
module rcf_reset_cause_chk (
    input wire logic        sys_clk,          // Core clock
    input wire logic        reset,            // Async reset, high
    input wire logic        ext_reset_pin,    // Pin, low = reset
    input wire logic        lp_brownout_req,  // Low-power brown-out
    input wire logic        wdt_expire,       // Watchdog pulse
    input wire logic        soft_reset_exec,  // Reset instruction
    input wire logic        stack_ovf_evt,    // Overflow pulse
    input wire logic        irq_wake,         // Wake pulse
    input wire logic        sleep_enter,      // Sleep pulse
    input wire logic [12:0] cur_pc,           // Sleep PC
    input wire logic [1:0]  reg_addr,         // Register address
    input wire logic [7:0]  reg_wdata,        // Write data
    input wire logic        reg_wr,           // Write strobe
    input wire logic        reg_rd,           // Read strobe
    input wire logic [7:0]  reg_rdata,        // Read data
    input wire logic        core_hold,        // Core held
    input wire logic        pc_load,          // PC load pulse
    input wire logic [12:0] pc_vector,        // PC load value
    input wire logic        irq_push          // Push pulse
);
    logic [1:0] cfg_ff;
    logic       asleep_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Shadow of config and sleep, so checks know which case applies
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) cfg_ff <= 2'h0;
        else if (reg_wr && reg_addr == `RCF_OFS_CONFIG)
            cfg_ff <= reg_wdata[1:0];
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) asleep_ff <= 1'b0;
        else if (sleep_enter) asleep_ff <= 1'b1;
        else if (irq_wake || wdt_expire || core_hold) asleep_ff <= 1'b0;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_restart0;
        pc_load && pc_vector == `RCF_VEC_RESET;
    endsequence
    sequence s_resume;
        pc_load && pc_vector == 13'(cur_pc + 13'h1);
    endsequence
    a_wdt_awake_restart: assert property (
        wdt_expire && !asleep_ff |-> ##[1:2] s_restart0)
        else $error("watchdog reset did not restart at zero");
    a_wdt_sleep_resume: assert property (
        wdt_expire && asleep_ff |-> ##[1:2] s_resume)
        else $error("watchdog wake did not resume after sleep");
    a_irq_wake_resume: assert property (
        irq_wake && asleep_ff |-> ##[1:2] s_resume)
        else $error("interrupt wake did not resume after sleep");
    a_irq_push_vector: assert property (
        irq_push |-> pc_load && pc_vector == `RCF_VEC_IRQ)
        else $error("push without load of the interrupt vector");
    a_soft_restart: assert property (
        soft_reset_exec && !wdt_expire |-> ##[1:2] s_restart0)
        else $error("reset instruction did not restart at zero");
    a_ovf_restart: assert property (
        stack_ovf_evt && cfg_ff[0] |-> ##[1:2] s_restart0)
        else $error("stack overflow did not restart at zero");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cause_bit5_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == `RCF_OFS_CAUSE |-> !reg_rdata[5])
        else $error("unused cause bit reads one");
    a_pin_hold_core: assert property (
        !ext_reset_pin [*8] |-> core_hold)
        else $error("core not held while pin low");
    a_lp_hold_core: assert property (
        lp_brownout_req [*8] |-> core_hold)
        else $error("core not held on low-power brown-out");
endmodule

/* verif/rcf_reset_cause_tb.sv */
// Self-checking bench of the reset-cause block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
module rcf_reset_cause_tb;
    import rcf_pkg::*;
    localparam logic [6:0] E_WDT = 7'h40, E_SOFT = 7'h20, E_OVF = 7'h10;
    localparam logic [6:0] E_UNF = 7'h08, E_IRQ = 7'h04, E_SLP = 7'h02;
    localparam logic [6:0] E_NID = 7'h01;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  lvl = 3'h1;
    logic [6:0]  ev = 7'h00;
    logic [12:0] cur_pc = 13'h0000;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        core_hold, pc_load, irq_push;
    logic [12:0] pc_vector, nx;
    logic [7:0]  rd_q[$];
    logic [13:0] pc_q[$];
    logic [7:0]  rnd;
    logic        rd_seen = 1'b0;
    logic        pc_watch = 1'b0;
    int          miscompares = 0;
    int          samples_checked = 0;
    integer      seed = 32'h9962;

    always #12.5 sys_clk = ~sys_clk;

    rcf_reset_cause dut_u (
        .sys_clk(sys_clk), .reset(reset), .brownout_req(lvl[1]),
        .lp_brownout_req(lvl[2]), .ext_reset_pin(lvl[0]),
        .wdt_expire(ev[6]), .soft_reset_exec(ev[5]), .stack_ovf_evt(ev[4]),
        .stack_unf_evt(ev[3]), .irq_wake(ev[2]), .sleep_enter(ev[1]),
        .next_instr_done(ev[0]), .cur_pc(cur_pc), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_hold(core_hold), .pc_load(pc_load),
        .pc_vector(pc_vector), .irq_push(irq_push)
    );
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_rd(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] reg_rdata expected %h seen %h", e, g);
        end
    endtask
    task automatic check_pc(input logic [13:0] e, input logic [13:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] pc_vector,irq_push expected %h seen %h", e, g);
        end
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Drivers; every op request is one cycle, then a short settle gap
    // ------------------------------------------------------------
    task automatic op(input logic w, input logic r, input logic [1:0] a,
                      input logic [7:0] d, input logic [6:0] e);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        ev <= e;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        ev <= 7'h00;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        op(1'b0, 1'b1, a, 8'h00, 7'h00);
    endtask
    // Level requests pass the pin filter, so hold them well past it
    // Each level call restarts the core once, on the asserting edge
    task automatic level(input logic [2:0] l);
        pc_q.push_back(14'h0000);
        @(posedge sys_clk);
        lvl <= l;
        repeat (12) @(posedge sys_clk);
        lvl <= 3'h1;
        repeat (12) @(posedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // Monitor: oldest note against each result as it appears
    // ------------------------------------------------------------
    always @(posedge sys_clk) rd_seen <= reg_rd & ~reset;
    always @(negedge sys_clk) begin
        if (rd_seen) check_rd(rd_q.pop_front(), reg_rdata);
        if (!reset && pc_watch && pc_load)
            check_pc(pc_q.size() > 0 ? pc_q.pop_front() : 'x,
                     {pc_vector, irq_push});
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pc_watch <= 1'b1;
        rd(2'h0, 8'h1C);
        rd(2'h1, 8'h18);
        rd(2'h3, 8'h00);
        rnd = 8'($random(seed));
        op(1'b1, 1'b0, 2'h0, rnd, 7'h00);
        rd(2'h0, rnd & 8'hDF);
        op(1'b1, 1'b0, 2'h0, 8'hFF, 7'h00);
        rd(2'h0, 8'hDF);
        pc_q.push_back(14'h0000);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_WDT);
        rd(2'h0, 8'hCF);
        rd(2'h1, 8'h08);
        pc_q.push_back(14'h0000);
        op(1'b1, 1'b0, 2'h0, 8'hFF, E_SOFT);
        rd(2'h0, 8'hDB);
        op(1'b1, 1'b0, 2'h0, 8'h1B, 7'h00);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_OVF);
        rd(2'h0, 8'h1B);
        op(1'b1, 1'b0, 2'h2, 8'h03, 7'h00);
        pc_q.push_back(14'h0000);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_OVF);
        rd(2'h0, 8'h9B);
        pc_q.push_back(14'h0000);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_UNF);
        rd(2'h0, 8'hDB);
        cur_pc <= 13'($random(seed));
        op(1'b0, 1'b0, 2'h0, 8'h00, E_IRQ);
        rd(2'h1, 8'h08);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_SLP);
        nx = cur_pc + 13'h1;
        pc_q.push_back({nx, 1'b0});
        pc_q.push_back({13'h0004, 1'b1});
        op(1'b0, 1'b0, 2'h0, 8'h00, E_IRQ);
        rd(2'h1, 8'h10);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_NID);
        rd(2'h0, 8'hDB);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_SLP);
        pc_q.push_back({nx, 1'b0});
        op(1'b0, 1'b0, 2'h0, 8'h00, E_WDT);
        rd(2'h1, 8'h00);
        rd(2'h0, 8'hDB);
        level(3'h0);
        rd(2'h0, 8'hD3);
        rd(2'h1, 8'h00);
        op(1'b0, 1'b0, 2'h0, 8'h00, E_SLP);
        level(3'h0);
        rd(2'h1, 8'h10);
        level(3'h3);
        rd(2'h0, 8'h1E);
        rd(2'h1, 8'h18);
        op(1'b1, 1'b0, 2'h0, 8'hFF, 7'h00);
        level(3'h5);
        rd(2'h0, 8'h1E);
        repeat (4) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule

bind rcf_reset_cause rcf_reset_cause_chk chk_u (
    .sys_clk(sys_clk), .reset(reset), .ext_reset_pin(ext_reset_pin),
    .lp_brownout_req(lp_brownout_req), .wdt_expire(wdt_expire),
    .soft_reset_exec(soft_reset_exec), .stack_ovf_evt(stack_ovf_evt),
    .irq_wake(irq_wake), .sleep_enter(sleep_enter), .cur_pc(cur_pc),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_hold(core_hold),
    .pc_load(pc_load), .pc_vector(pc_vector), .irq_push(irq_push)
);
